// File: core/icg_pkg.sv
package icg_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_IRQ = 8;
  localparam int PRIO_W = 3;
  localparam int NUM_PERIPH = 8;

  // ==========================================================
  // Peripheral map of this variant
  localparam int SECOND_UART_IDX = 3;
  // Peripherals built on this variant; the second UART is absent
  localparam logic [NUM_PERIPH-1:0] PERIPH_PRESENT = 8'hF7;
  // Absent peripherals whose disable bit still holds a written value
  localparam logic [NUM_PERIPH-1:0] DIS_WRITABLE_ABSENT = 8'h08;
  // Enabled state after reset for every disable bit
  localparam logic DIS_RESET_VAL = 1'h0;
  // Read value of an absent, non-writable disable bit
  localparam logic DIS_ABSENT_VAL = 1'h1;

  // ==========================================================
  // Reset values
  localparam logic [2:0] STATUS_RESET = 3'h0;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ST_RUN,
    ST_IDLE,
    ST_SLEEP,
    ST_OSC_WAIT
  } icg_state_t;

  // Reset causes, one-cycle pulses from the reset logic
  typedef struct packed {
    logic por;
    logic brown_out_reset;
    logic master_clear_reset_pin;
  } icg_rst_src_t;

  // Fields of reset_cause_status_reg kept by this block
  typedef struct packed {
    logic idle;
    logic sleep;
    logic watchdog_timeout_flag;
  } icg_status_t;

endpackage

// File: core/icg_pmd_bits.sv
`timescale 1ns/1ps

module icg_module_disable
  import icg_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic mod_dis_wr,
  input wire logic [NUM_PERIPH-1:0] mod_dis_wdata,
  output logic [NUM_PERIPH-1:0] peripheral_module_disable
);

  // ==========================================================
  // One disable bit per peripheral
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PERIPH; gi++) begin : g_bit
      if (PERIPH_PRESENT[gi] || DIS_WRITABLE_ABSENT[gi]) begin : g_store
        logic bit_reg;
        logic bit_next;
        // Written value is kept; absent second UART still reads back a set bit
        always_comb begin
          bit_next = bit_reg;
          if (mod_dis_wr) begin
            bit_next = mod_dis_wdata[gi]; // RULE_13
          end
        end
        // Reset to enabled so present modules run out of reset
        always_ff @(posedge core_clk) begin
          if (!nrst) begin
            bit_reg <= DIS_RESET_VAL; // RULE_11
          end else begin
            bit_reg <= bit_next;
          end
        end
        assign peripheral_module_disable[gi] = bit_reg;
      end else begin : g_fixed
        // Nothing to gate, so the bit is a constant
        assign peripheral_module_disable[gi] = DIS_ABSENT_VAL;
      end
    end
  endgenerate

  // ==========================================================
  // Checks
  a_u2_readback: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_13
    mod_dis_wr && mod_dis_wdata[SECOND_UART_IDX] |=> peripheral_module_disable[SECOND_UART_IDX])
    else $error("second uart disable bit does not read back set");

  a_dis_reset_on: assert property (@(posedge core_clk) // RULE_11
    !nrst |=> (peripheral_module_disable & PERIPH_PRESENT) == '0)
    else $error("present module not enabled after reset");

endmodule

// File: core/icg_power_ctrl.sv
`timescale 1ns/1ps

// Behaviour
// RULE_01: Idle stops CPU clock, peripherals, oscillator run
// RULE_02: Per-module idle-stop bit gates peripheral in Idle
// RULE_03: Low-power RC stays on when failure detect enabled
// RULE_04: Enabled prioritised interrupt, reset, watchdog wake Idle
// RULE_05: Wake restores CPU clock, resumes next instruction
// RULE_06: Interrupt wake services interrupt, sets Idle flag
// RULE_07: Non-power-on reset sets Idle flag, power-on clears
// RULE_08: Watchdog wake sets Idle and watchdog flags
// RULE_09: Idle wake has no start-up delay
// RULE_10: Disable bit stops module clocks and register access
// RULE_11: Module runs only if enabled and present
// RULE_12: Disable bit change acts one instruction cycle later
// RULE_13: Absent second UART disable bit reads back set
// RULE_14: Resets wake Sleep; non-power-on sets Sleep flag
// RULE_15: Power-save instruction with Idle operand enters Idle
module icg_power_ctrl
  import icg_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic power_save_instruction,
  input wire logic power_save_idle_op,
  input wire logic [NUM_IRQ-1:0] irq_req,
  input wire logic [NUM_IRQ-1:0] interrupt_enable_bit,
  input wire logic [NUM_IRQ-1:0][PRIO_W-1:0] irq_prio,
  input wire logic [PRIO_W-1:0] cpu_prio,
  input wire icg_rst_src_t rst_src,
  input wire logic wdt_enable,
  input wire logic wdt_timeout,
  input wire logic fscm_enable,
  input wire logic osc_ready,
  input wire icg_status_t status_clr,
  input wire logic [NUM_PERIPH-1:0] periph_idle_stop,
  input wire logic mod_dis_wr,
  input wire logic [NUM_PERIPH-1:0] mod_dis_wdata,
  output logic cpu_clk_en,
  output logic osc_src_en,
  output logic low_power_rc_oscillator_en,
  output logic [NUM_PERIPH-1:0] periph_clk_en,
  output logic [NUM_PERIPH-1:0] periph_reg_en,
  output logic [NUM_PERIPH-1:0] mod_dis_rdata,
  output icg_status_t reset_cause_status_reg,
  output logic resume_next_instr,
  output logic irq_service,
  output logic in_idle
);

  // ==========================================================
  // Disable bits
  logic [NUM_PERIPH-1:0] peripheral_module_disable;

  icg_module_disable i_icg_module_disable (
    .core_clk(core_clk),
    .nrst(nrst),
    .mod_dis_wr(mod_dis_wr),
    .mod_dis_wdata(mod_dis_wdata),
    .peripheral_module_disable(peripheral_module_disable)
  );

  // ==========================================================
  // Wake sources
  logic [NUM_IRQ-1:0] irq_hit;
  logic wake_irq;
  logic wake_wdt;
  logic rst_any;

  // One comparator per interrupt line against the running priority
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IRQ; gi++) begin : g_irq
      assign irq_hit[gi] = irq_req[gi] && interrupt_enable_bit[gi]
                           && (irq_prio[gi] > cpu_prio); // RULE_04
    end
  endgenerate

  assign wake_irq = |irq_hit; // RULE_04
  assign wake_wdt = wdt_enable && wdt_timeout;
  assign rst_any = rst_src.por || rst_src.brown_out_reset || rst_src.master_clear_reset_pin;

  // ==========================================================
  // Power state and status flags
  icg_state_t state_reg;
  icg_state_t state_next;
  logic cpu_clk_en_next;
  logic resume_next;
  logic service_next;
  icg_status_t status_next;

  // Software clears first so that a hardware set in the same cycle wins
  always_comb begin
    state_next = state_reg;
    cpu_clk_en_next = cpu_clk_en;
    resume_next = 1'h0;
    service_next = 1'h0;
    status_next = reset_cause_status_reg & ~status_clr;
    case (state_reg)
      ST_RUN: begin
        if (power_save_instruction) begin
          cpu_clk_en_next = 1'h0; // RULE_15
          state_next = power_save_idle_op ? ST_IDLE : ST_SLEEP; // RULE_15
        end
      end
      ST_IDLE: begin
        // Oscillator never stopped, so the clock returns at once
        if (rst_any || wake_wdt || wake_irq) begin
          state_next = ST_RUN; // RULE_04
          cpu_clk_en_next = 1'h1; // RULE_09
          status_next.idle = 1'h1; // RULE_06 RULE_07 RULE_08
          resume_next = !rst_any; // RULE_05
          service_next = !rst_any && wake_irq; // RULE_06
        end
      end
      ST_SLEEP: begin
        if (rst_any) begin
          state_next = ST_RUN; // RULE_14
          cpu_clk_en_next = 1'h1;
          status_next.sleep = 1'h1; // RULE_14
        end else if (wake_wdt || wake_irq) begin
          state_next = ST_OSC_WAIT;
          status_next.sleep = 1'h1;
        end
      end
      ST_OSC_WAIT: begin
        // Interrupt or watchdog wake from Sleep holds the CPU until the oscillator is stable
        if (rst_any) begin
          state_next = ST_RUN;
          cpu_clk_en_next = 1'h1;
        end else if (osc_ready) begin
          state_next = ST_RUN;
          cpu_clk_en_next = 1'h1;
          resume_next = 1'h1;
          service_next = wake_irq;
        end
      end
      default: begin
        state_next = ST_RUN;
        cpu_clk_en_next = 1'h1;
      end
    endcase
    if (wake_wdt) begin
      status_next.watchdog_timeout_flag = 1'h1; // RULE_08
    end
    // Power-on reset overrides every other source for the state and the Idle and Sleep flags
    if (rst_src.por) begin
      state_next = ST_RUN;
      cpu_clk_en_next = 1'h1;
      status_next.idle = 1'h0; // RULE_07
      status_next.sleep = 1'h0; // RULE_14
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_reg <= ST_RUN;
      cpu_clk_en <= 1'h1;
      resume_next_instr <= 1'h0;
      irq_service <= 1'h0;
      reset_cause_status_reg <= STATUS_RESET;
    end else begin
      state_reg <= state_next;
      cpu_clk_en <= cpu_clk_en_next;
      resume_next_instr <= resume_next;
      irq_service <= service_next;
      reset_cause_status_reg <= status_next;
    end
  end

  // ==========================================================
  // Clock gates
  logic osc_src_en_next;
  logic low_power_rc_oscillator_en_next;
  logic in_idle_next;
  logic [NUM_PERIPH-1:0] periph_clk_en_next;
  logic [NUM_PERIPH-1:0] periph_reg_en_next;

  // Gates follow the next state so they switch on the same edge as the CPU.
  // Disable bits come from flops, so a write acts one cycle later.
  always_comb begin
    osc_src_en_next = (state_next != ST_SLEEP); // RULE_01
    low_power_rc_oscillator_en_next = fscm_enable; // RULE_03
    in_idle_next = (state_next == ST_IDLE);
    for (int i = 0; i < NUM_PERIPH; i++) begin
      periph_reg_en_next[i] = !peripheral_module_disable[i] && PERIPH_PRESENT[i]; // RULE_10 RULE_11
      periph_clk_en_next[i] = periph_reg_en_next[i] // RULE_12
                              && !(in_idle_next && periph_idle_stop[i]) // RULE_02
                              && (state_next == ST_RUN || in_idle_next); // RULE_01
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      osc_src_en <= 1'h1;
      low_power_rc_oscillator_en <= 1'h0;
      in_idle <= 1'h0;
      periph_clk_en <= '0;
      periph_reg_en <= '0;
      mod_dis_rdata <= '0;
    end else begin
      osc_src_en <= osc_src_en_next;
      low_power_rc_oscillator_en <= low_power_rc_oscillator_en_next;
      in_idle <= in_idle_next;
      periph_clk_en <= periph_clk_en_next;
      periph_reg_en <= periph_reg_en_next;
      mod_dis_rdata <= peripheral_module_disable;
    end
  end

  // ==========================================================
  // Checks
  sequence s_idle_irq;
    state_reg == ST_IDLE && wake_irq && !rst_any;
  endsequence

  sequence s_idle_wdt;
    state_reg == ST_IDLE && wake_wdt && !rst_any && !wake_irq;
  endsequence

  a_idle_entry: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_15
    state_reg == ST_RUN && power_save_instruction && power_save_idle_op && !rst_src.por
    |=> !cpu_clk_en && in_idle && osc_src_en)
    else $error("idle entry did not stop the cpu clock");

  a_idle_irq_wake: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_06
    s_idle_irq |=> cpu_clk_en && irq_service && resume_next_instr
    && reset_cause_status_reg.idle)
    else $error("interrupt wake from idle incomplete");

  a_wdt_wake: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_08
    s_idle_wdt |=> cpu_clk_en && !irq_service && reset_cause_status_reg.idle
    && reset_cause_status_reg.watchdog_timeout_flag)
    else $error("watchdog wake from idle incomplete");

  a_idle_hold: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_01
    in_idle |-> !cpu_clk_en && osc_src_en)
    else $error("idle clocks wrong");

  a_por_clear: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_07
    rst_src.por |=> !reset_cause_status_reg.idle && !reset_cause_status_reg.sleep
    && cpu_clk_en)
    else $error("power-on reset did not clear flags");

  a_reset_idle: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_07
    state_reg == ST_IDLE && (rst_src.brown_out_reset || rst_src.master_clear_reset_pin)
    && !rst_src.por |=> reset_cause_status_reg.idle && cpu_clk_en && !resume_next_instr)
    else $error("reset from idle did not set idle flag");

  a_sleep_reset: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_14
    state_reg == ST_SLEEP && (rst_src.brown_out_reset || rst_src.master_clear_reset_pin)
    && !rst_src.por |=> reset_cause_status_reg.sleep && state_reg == ST_RUN)
    else $error("reset from sleep wrong");

  a_rc_idle: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_03
    in_idle && $past(fscm_enable) |-> low_power_rc_oscillator_en)
    else $error("low-power rc stopped in idle");

  a_dis_delay: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_12
    mod_dis_wr && mod_dis_wdata[0] |=> ##1 !periph_clk_en[0] && !periph_reg_en[0])
    else $error("disable bit did not stop module after one cycle");

  a_periph_idle_stop: assert property (@(posedge core_clk) disable iff (!nrst) // RULE_02
    in_idle && $past(periph_idle_stop[1]) |-> !periph_clk_en[1])
    else $error("idle-stop peripheral still clocked");

endmodule

// File: test/icg_cpu_model.sv
`timescale 1ns/1ps

// ==========================================================
// Core model: one instruction per cycle while its clock runs
module icg_cpu_model (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic cpu_clk_en,
  input wire logic irq_service,
  output logic [15:0] pc,
  output logic [7:0] isr_cnt
);
  // A gated clock freezes the program counter, so no work is lost or replayed
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pc <= 16'h0000;
      isr_cnt <= 8'h00;
    end else begin
      if (cpu_clk_en) begin
        pc <= pc + 16'h0001;
      end
      if (irq_service) begin
        isr_cnt <= isr_cnt + 8'h01;
      end
    end
  end
endmodule

// File: test/idle_and_module_clock_gating_tb_top.sv
`timescale 1ns/1ps

module idle_and_module_clock_gating_tb_top;
  import icg_pkg::*;
  // ==========================================================
  // Stimulus and observed signals
  typedef struct packed {
    logic [3:0] ev;
    icg_status_t st;
    logic rs;
    logic sv;
  } icg_row_t;
  logic core_clk = 1'h0;
  logic nrst = 1'h0;
  logic ps = 1'h0;
  logic op = 1'h0;
  logic [7:0] irq_req = 8'h00;
  logic [7:0] ien = 8'h04;
  logic [NUM_IRQ-1:0][PRIO_W-1:0] prio = '{2: 3'h5, default: 3'h0};
  icg_rst_src_t rst_src = 3'h0;
  icg_status_t sclr = 3'h0;
  logic wdt_en = 1'h1;
  logic wdt_to = 1'h0;
  logic fscm = 1'h0;
  logic osc_rdy = 1'h0;
  logic pwr = 1'h0;
  logic [7:0] pwd = 8'h00;
  logic [7:0] istop = 8'h03;
  logic cpu_en, osc_en, rc_on, rsm, svc, idl;
  logic [7:0] pclk, preg, prd, isr;
  logic [15:0] pc, p;
  icg_status_t st;
  int num_errors = 0;
  int checks = 0;
  // Wake events {irq, wdt, brown-out, master clear} and the answer each should give
  icg_row_t rows [4] = '{'{4'h8, 3'h4, 1'h1, 1'h1}, '{4'h4, 3'h5, 1'h1, 1'h0},
                         '{4'h2, 3'h4, 1'h0, 1'h0}, '{4'h1, 3'h4, 1'h0, 1'h0}};

  icg_power_ctrl i_icg_power_ctrl (.core_clk(core_clk), .nrst(nrst),
    .power_save_instruction(ps), .power_save_idle_op(op), .irq_req(irq_req),
    .interrupt_enable_bit(ien), .irq_prio(prio), .cpu_prio(3'h2), .rst_src(rst_src),
    .wdt_enable(wdt_en), .wdt_timeout(wdt_to), .fscm_enable(fscm), .osc_ready(osc_rdy),
    .status_clr(sclr), .periph_idle_stop(istop), .mod_dis_wr(pwr), .mod_dis_wdata(pwd),
    .cpu_clk_en(cpu_en), .osc_src_en(osc_en), .low_power_rc_oscillator_en(rc_on),
    .periph_clk_en(pclk),
    .periph_reg_en(preg), .mod_dis_rdata(prd), .reset_cause_status_reg(st),
    .resume_next_instr(rsm), .irq_service(svc), .in_idle(idl));
  icg_cpu_model i_icg_cpu_model (.core_clk(core_clk), .nrst(nrst), .cpu_clk_en(cpu_en),
    .irq_service(svc), .pc(pc), .isr_cnt(isr));

  // ==========================================================
  // Clock, watchdog and shared tasks
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  // Whole run is some 64 cycles; this leaves ample margin
  initial begin
    #20000;
    num_errors++;
    stop_test();
  end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic cyc();
    @(negedge core_clk);
  endtask
  task automatic enter(input logic o);
    ps = 1'h1;
    op = o;
    cyc();
    ps = 1'h0;
  endtask
  // Pulses last one cycle; the answer is read at the following falling edge
  task automatic wake(input logic [3:0] ev);
    irq_req = ev[3] ? 8'h04 : 8'h00;
    wdt_to = ev[2];
    rst_src = {1'h0, ev[1], ev[0]};
    cyc();
    irq_req = 8'h00;
    wdt_to = 1'h0;
    rst_src = 3'h0;
  endtask
  task automatic clr();
    sclr = 3'h7;
    cyc();
    sclr = 3'h0;
    cyc();
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) cyc();
    chk("rst_cpu", cpu_en, 1'h1);
    chk("rst_st", st, 3'h0);
    nrst = 1'h1;
    cyc();
    chk("rst_pclk", pclk, PERIPH_PRESENT);
    chk("rst_preg", preg, PERIPH_PRESENT);
    for (int i = 0; i < 4; i++) begin
      enter(1'h1);
      chk("cpu_en", cpu_en, 1'h0);
      chk("in_idle", idl, 1'h1);
      chk("osc_en", osc_en, 1'h1);
      chk("idle_pclk", pclk, PERIPH_PRESENT & ~istop);
      p = pc;
      cyc();
      chk("pc_hold", pc[7:0], p[7:0]);
      wake(rows[i].ev);
      chk("woke_cpu", cpu_en, 1'h1);
      chk("woke", idl, 1'h0);
      chk("status", st, rows[i].st);
      chk("resume", rsm, rows[i].rs);
      chk("service", svc, rows[i].sv);
      clr();
    end
    chk("isr", isr, 8'h01);
    // Equal priority, disabled line and disabled watchdog do not wake
    prio[2] = 3'h2;
    enter(1'h1);
    irq_req = 8'h04;
    cyc();
    chk("eq_prio", idl, 1'h1);
    ien = 8'h00;
    prio[2] = 3'h5;
    cyc();
    chk("dis_irq", idl, 1'h1);
    irq_req = 8'h00;
    wdt_en = 1'h0;
    wake(4'h4);
    chk("wdt_off", idl, 1'h1);
    wdt_en = 1'h1;
    ien = 8'h04;
    // Power-on clears the flag a master clear had set
    wake(4'h1);
    enter(1'h1);
    rst_src = 3'h4;
    cyc();
    rst_src = 3'h0;
    chk("por_st", st, 3'h0);
    chk("por_cpu", cpu_en, 1'h1);
    fscm = 1'h1;
    cyc();
    chk("rc_run", rc_on, 1'h1);
    enter(1'h1);
    chk("rc_idle", rc_on, 1'h1);
    wake(4'h1);
    clr();
    // A flag set and its software clear in one cycle: the set wins
    enter(1'h1);
    sclr = 3'h7;
    wdt_to = 1'h1;
    cyc();
    sclr = 3'h0;
    wdt_to = 1'h0;
    chk("set_wins", st, 3'h5);
    clr();
    // Sleep: watchdog wake waits for the oscillator, reset wake does not
    enter(1'h0);
    chk("slp_osc", osc_en, 1'h0);
    wake(4'h4);
    chk("osc_wait", cpu_en, 1'h0);
    osc_rdy = 1'h1;
    cyc();
    osc_rdy = 1'h0;
    chk("slp_cpu", cpu_en, 1'h1);
    chk("slp_st", st, 3'h3);
    clr();
    enter(1'h0);
    wake(4'h2);
    chk("slp_brown", st, 3'h2);
    chk("brown_cpu", cpu_en, 1'h1);
    // Disable bits act one cycle after the write, both ways
    pwr = 1'h1;
    pwd = 8'h09;
    cyc();
    pwr = 1'h0;
    chk("dis_lat", pclk, 8'hF7);
    cyc();
    chk("dis_clk", pclk, 8'hF6);
    chk("dis_reg", preg, 8'hF6);
    chk("dis_rd", prd, 8'h09);
    pwr = 1'h1;
    pwd = 8'h00;
    cyc();
    pwr = 1'h0;
    chk("dis_lat2", pclk, 8'hF6);
    cyc();
    chk("dis_on", pclk, 8'hF7);
    chk("dis_rd0", prd, 8'h00);
    stop_test();
  end
endmodule
